// ==== inc/sdram_xlat_map.vh ====
// Register offsets, field positions and reset values of the translator
`ifndef SDRAM_XLAT_MAP_VH
`define SDRAM_XLAT_MAP_VH

// Register byte offsets within the controller window
`define OFS_GFX_BASE 16'h8414
`define OFS_TAG_INDEX 16'h8418
`define OFS_TAG_ACCESS 16'h841c
`define OFS_MEM_CONFIG 16'h8420

// Graphics region base register fields
`define GB_BASE_LSB 0
`define GB_BASE_MSB 10
`define GB_SEL_LSB 12
`define GB_SEL_MSB 15
`define GB_RESET 32'h00000000

// Tag index register field
`define TI_MSB 9
`define TI_RESET 32'h00000000

// Tag access register fields
`define TA_VALID 0
`define TA_DIRTY 1

// Memory configuration register fields
`define MC_PAGE_LSB 0
`define MC_PAGE_MSB 1
`define MC_FOUR_BANK 2
`define MC_POP_LSB 4
`define MC_POP_MSB 7
`define MC_TOP_LSB 16
`define MC_TOP_MSB 26
`define MC_RESET 32'h07ff0000

// Physical address slice compared with region fields
`define PA_REGION_LSB 19
`define PA_REGION_MSB 29

// Bus response codes
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// ==== core/sdram_row_col_map.v ====
// Physical-to-SDRAM row, column and bank bit mapping datapath
`timescale 1ns/10ps
module sdram_row_col_map (
    // Address within the selected DIMM
    input wire [29:0] local_addr,
    // Geometry
    input wire [1:0] page_sel,
    input wire four_bank,
    input wire low_order_interleave,
    // Mapped lines
    output reg [12:0] row_addr,
    output reg [12:0] col_addr,
    output reg [1:0] bank_addr,
    output reg cs_bit
);

    reg [29:0] shifted; // Address with page-size doubling removed
    reg [29:0] row_src; // Address shifted down to the row field
    reg [4:0] row_lsb; // Lowest bit of the row field within the shifted address

    // Combinational mapping, one shift per page doubling
    always @* begin
        shifted = local_addr >> page_sel;
        // Column phase: A3..A9 on lines 0..6 always
        col_addr = 13'h0000;
        col_addr[6:0] = local_addr[9:3];
        // 2 KB and 4 KB pages add A10, 4 KB adds A11
        col_addr[7] = (page_sel != 2'h0) ? local_addr[10] : 1'b0;
        col_addr[8] = (page_sel == 2'h2) ? local_addr[11] : 1'b0;
        // Bank just above the page bits
        bank_addr = four_bank ? shifted[11:10] : {1'b0, shifted[10]};
        // Chip select bit sits above the bank bits when interleaved
        cs_bit = four_bank ? shifted[12] : shifted[11];
        if (!low_order_interleave) begin
            cs_bit = 1'b0; // Chip select comes from the region instead
        end
        // Row starts above bank bits, plus one for the interleave select
        row_lsb = 5'h0b + {4'h0, four_bank} + {4'h0, low_order_interleave};
        row_src = shifted >> row_lsb;
        row_addr = row_src[12:0];
    end

endmodule

// ==== core/sdram_address_translation.v ====
// SDRAM address translator with AXI4-Lite control registers and tag memory
`timescale 1ns/10ps
`include "sdram_xlat_map.vh"

module sdram_address_translation (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // AXI4-Lite write address
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [15:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [15:0] s_axi_araddr,
    // AXI4-Lite read data
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // Translation request
    input wire xlat_valid,
    input wire [31:0] xlat_addr,
    // Translation result
    output reg out_valid,
    output reg [12:0] row_addr_q,
    output reg [12:0] col_addr_q,
    output reg [1:0] bank_addr_q,
    output reg [3:0] chip_select_n_q,
    output reg [7:0] byte_mask_n_q,
    output reg gfx_hit_q,
    output reg low_order_interleave_q
);

    // Register index codes
    localparam REG_NONE = 3'd0;
    localparam REG_GFX = 3'd1;
    localparam REG_TIDX = 3'd2;
    localparam REG_TACC = 3'd3;
    localparam REG_CFG = 3'd4;

    // Decodes a byte address into a register index
    function [2:0] reg_decode;
        input [15:0] addr;
        begin
            case (addr)
                `OFS_GFX_BASE: reg_decode = REG_GFX;
                `OFS_TAG_INDEX: reg_decode = REG_TIDX;
                `OFS_TAG_ACCESS: reg_decode = REG_TACC;
                `OFS_MEM_CONFIG: reg_decode = REG_CFG;
                default: reg_decode = REG_NONE;
            endcase
        end
    endfunction

    // Merges write data into an old word under byte strobes
    function [31:0] strobe_merge;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0] strb;
        integer i;
        begin
            strobe_merge = old_word;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    strobe_merge[i*8 +: 8] = new_word[i*8 +: 8];
                end
            end
        end
    endfunction

    // Software-visible registers
    reg [31:0] gfx_base_q; // Graphics base and debug select
    reg [31:0] tag_index_q; // Tag memory entry pointer
    reg [31:0] mem_cfg_q; // Page size, bank count, population, DIMM top
    // Dirty/valid tag memory, one two-bit entry per index
    reg [1:0] tag_mem [0:1023];

    // Write channel holding registers
    reg aw_held_q; // Write address captured
    reg [15:0] aw_addr_q;
    reg w_held_q; // Write data captured
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // Accept each write channel while its holder is empty and no response waits
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    // Accept a read only while no read data waits
    assign s_axi_arready = !s_axi_rvalid;

    wire do_write = aw_held_q && w_held_q; // Both halves present
    wire [2:0] wr_reg = reg_decode(aw_addr_q);
    wire [2:0] rd_reg = reg_decode(s_axi_araddr);
    wire [9:0] tag_ptr = tag_index_q[`TI_MSB:0];
    wire [31:0] wr_word_gfx = strobe_merge(gfx_base_q, w_data_q, w_strb_q);
    wire [31:0] wr_word_idx = strobe_merge(tag_index_q, w_data_q, w_strb_q);
    wire [31:0] wr_word_cfg = strobe_merge(mem_cfg_q, w_data_q, w_strb_q);

    // Write address and data capture, in either order
    always @(posedge ref_clk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 16'h0000;
            w_held_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else begin
            if (do_write) begin
                // Both consumed when the register is updated
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
            end
        end
    end

    // Register updates and write response
    always @(posedge ref_clk) begin
        if (rst) begin
            gfx_base_q <= `GB_RESET;
            tag_index_q <= `TI_RESET;
            mem_cfg_q <= `MC_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                case (wr_reg)
                    REG_GFX: begin
                        // Base, debug select; reserved bits held at zero
                        gfx_base_q <= wr_word_gfx & 32'h0000f7ff;
                    end
                    REG_TIDX: begin
                        tag_index_q <= wr_word_idx & 32'h000003ff;
                    end
                    REG_TACC: begin
                        // Tag memory written in its own process
                    end
                    REG_CFG: begin
                        mem_cfg_q <= wr_word_cfg & 32'h07ff00f7;
                    end
                    default: begin
                        s_axi_bresp <= `RESP_DECERR; // Unmapped address
                    end
                endcase
            end
        end
    end

    // Tag memory write: only the entry the index points at
    always @(posedge ref_clk) begin
        if (do_write && wr_reg == REG_TACC && w_strb_q[0]) begin
            tag_mem[tag_ptr] <= w_data_q[`TA_DIRTY:`TA_VALID];
        end
    end

    // Read data path, one cycle after the address is taken
    always @(posedge ref_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                case (rd_reg)
                    REG_GFX: begin
                        s_axi_rdata <= gfx_base_q;
                    end
                    REG_TIDX: begin
                        s_axi_rdata <= tag_index_q;
                    end
                    REG_TACC: begin
                        // Flags of the indexed entry only
                        s_axi_rdata <= {30'h00000000, tag_mem[tag_ptr]};
                    end
                    REG_CFG: begin
                        s_axi_rdata <= mem_cfg_q;
                    end
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RESP_DECERR; // Unmapped address
                    end
                endcase
            end
        end
    end

    // Configuration fields used by the translator
    wire [10:0] gfx_base = gfx_base_q[`GB_BASE_MSB:`GB_BASE_LSB];
    wire [1:0] page_sel = mem_cfg_q[`MC_PAGE_MSB:`MC_PAGE_LSB];
    wire four_bank = mem_cfg_q[`MC_FOUR_BANK];
    wire [3:0] populated = mem_cfg_q[`MC_POP_MSB:`MC_POP_LSB];
    wire [10:0] dimm_top = mem_cfg_q[`MC_TOP_MSB:`MC_TOP_LSB];

    // Region of the request in 512 KB units
    wire [10:0] region = xlat_addr[`PA_REGION_MSB:`PA_REGION_LSB];
    // Upper DIMM chosen by the most significant bits
    wire upper_dimm = (region >= dimm_top);
    // Address rebased into the selected DIMM
    wire [29:0] rebase = upper_dimm ? {dimm_top, 19'h00000} : 30'h00000000;
    wire [29:0] local_addr = xlat_addr[29:0] - rebase;
    // Pair full: low-order interleave switches on by itself
    wire pair_lo_full = populated[0] && populated[1];
    wire pair_hi_full = populated[2] && populated[3];
    wire low_order_interleave =
        upper_dimm ? pair_hi_full : pair_lo_full;

    // Mapped lines from the datapath
    wire [12:0] row_map;
    wire [12:0] col_map;
    wire [1:0] bank_map;
    wire cs_bit;

    // Row, column and bank bit selection
    sdram_row_col_map u_map (
        .local_addr(local_addr),
        .page_sel(page_sel),
        .four_bank(four_bank),
        .low_order_interleave(low_order_interleave),
        .row_addr(row_map),
        .col_addr(col_map),
        .bank_addr(bank_map),
        .cs_bit(cs_bit)
    );

    // Chip select index: DIMM from region, side from interleave
    wire [1:0] cs_index = {upper_dimm, low_order_interleave & cs_bit};

    // Registered translation result, one cycle after the request
    always @(posedge ref_clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            row_addr_q <= 13'h0000;
            col_addr_q <= 13'h0000;
            bank_addr_q <= 2'h0;
            chip_select_n_q <= 4'hf;
            byte_mask_n_q <= 8'hff;
            gfx_hit_q <= 1'b0;
            low_order_interleave_q <= 1'b0;
        end else begin
            out_valid <= xlat_valid;
            if (xlat_valid) begin
                row_addr_q <= row_map;
                col_addr_q <= col_map;
                bank_addr_q <= bank_map;
                chip_select_n_q <= ~(4'h1 << cs_index);
                // Low three bits only pick the byte lane
                byte_mask_n_q <= ~(8'h01 << xlat_addr[2:0]);
                // Graphics region from base upward
                gfx_hit_q <= (region >= gfx_base);
                low_order_interleave_q <= low_order_interleave;
            end
        end
    end

endmodule

// ==== bench/sdram_xlat_assertions.sv ====
// Port-level checker for the SDRAM address translator
`timescale 1ns/10ps
module sdram_xlat_checker (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Read channel
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    // Translation
    input wire xlat_valid,
    input wire [31:0] xlat_addr,
    input wire out_valid,
    input wire [12:0] col_addr_q,
    input wire [3:0] chip_select_n_q,
    input wire [7:0] byte_mask_n_q,
    input wire low_order_interleave_q
);
    // Byte lane and column slices of the request
    wire [2:0] lane = xlat_addr[2:0];
    wire [6:0] dword = xlat_addr[9:3];
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // Read address accepted
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Translation request accepted
    sequence s_req;
        xlat_valid;
    endsequence
    a_result_next: assert property (s_req |=> out_valid)
        else $error("no result after request");
    a_no_spurious: assert property (!xlat_valid |=> !out_valid)
        else $error("result without request");
    a_byte_lane: assert property (s_req |=>
        byte_mask_n_q == ~(8'h01 << $past(lane)))
        else $error("byte mask wrong");
    a_col_low: assert property (s_req |=>
        col_addr_q[6:0] == $past(dword))
        else $error("column low bits wrong");
    a_single_cs: assert property (out_valid |->
        $onehot(~chip_select_n_q))
        else $error("chip select not one-hot");
    a_high_order_cs: assert property (out_valid && !low_order_interleave_q
        |-> chip_select_n_q[1] && chip_select_n_q[3])
        else $error("interleave select without interleave");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule
bind sdram_address_translation sdram_xlat_checker chk_i (
    .ref_clk(ref_clk), .rst(rst), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .xlat_valid(xlat_valid), .xlat_addr(xlat_addr), .out_valid(out_valid),
    .col_addr_q(col_addr_q), .chip_select_n_q(chip_select_n_q),
    .byte_mask_n_q(byte_mask_n_q),
    .low_order_interleave_q(low_order_interleave_q));

// ==== bench/sdram_dimm_model.sv ====
// Behavioural DIMM pair that counts well-formed accesses
`timescale 1ns/10ps
module sdram_dimm_model (
    // Clock
    input wire ref_clk,
    // Command lines from the controller
    input wire out_valid,
    input wire [3:0] chip_select_n_q,
    input wire [7:0] byte_mask_n_q,
    // Accesses accepted
    output reg [15:0] hits
);
    // Pair shares one geometry, power-of-two banks
    parameter DIMM_BANKS = 4;
    initial hits = 16'h0;
    // Accept only one selected chip with one open byte lane
    always @(posedge ref_clk) begin
        if (out_valid && $onehot(~chip_select_n_q) &&
            $onehot(~byte_mask_n_q))
            hits <= hits + 16'h1;
    end
endmodule

// ==== bench/sdram_address_translation_tb.sv ====
// Self-checking bench for the SDRAM address translator
`timescale 1ns/10ps
module sdram_address_translation_tb;
    reg ref_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg s_axi_arvalid, s_axi_rready, xlat_valid;
    reg [15:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata, xlat_addr, r;
    reg [3:0] s_axi_wstrb, pop;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, out_valid, gfx_hit_q, low_order_interleave_q;
    wire [1:0] s_axi_bresp, s_axi_rresp, bank_addr_q;
    wire [31:0] s_axi_rdata;
    wire [12:0] row_addr_q, col_addr_q;
    wire [3:0] chip_select_n_q;
    wire [7:0] byte_mask_n_q;
    wire [15:0] hits;
    integer n_mismatch, checks, seed, cyc, i, c, n_req;
    reg [1:0] pg;
    reg fb, done;
    reg [10:0] top, gb;
    reg [9:0] ti [0:3];
    sdram_address_translation uut (
        .ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .xlat_valid, .xlat_addr, .out_valid,
        .row_addr_q, .col_addr_q, .bank_addr_q, .chip_select_n_q,
        .byte_mask_n_q, .gfx_hit_q, .low_order_interleave_q);
    // Far-side DIMM pair
    sdram_dimm_model dimm (.ref_clk, .out_valid, .chip_select_n_q,
        .byte_mask_n_q, .hits);
    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Cycle ceiling against a hang
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict;
        end
    end
    task chk(input [63:0] n, input [63:0] e, input [63:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("FAIL %0s expected %h seen %h", n, e, g);
            end
        end
    endtask
    // Bus write: offer address and data, hold each until taken
    task wr(input [15:0] a, input [31:0] d, input [1:0] er);
        begin
            @(posedge ref_clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            done = 1'b0;
            while (!done) begin
                @(posedge ref_clk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid) done = 1'b1;
            end
            s_axi_bready <= 1'b0;
            chk("bresp", er, s_axi_bresp);
        end
    endtask
    // Bus read: hold address until taken, take data with rvalid
    task rd(input [15:0] a, input [31:0] e, input [1:0] er);
        begin
            @(posedge ref_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            done = 1'b0;
            while (!done) begin
                @(posedge ref_clk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid) done = 1'b1;
            end
            s_axi_rready <= 1'b0;
            chk("rdata", e, s_axi_rdata);
            chk("rresp", er, s_axi_rresp);
        end
    endtask
    // Expected translation result for one physical address
    function [42:0] xp(input [31:0] a);
        reg [29:0] l, s;
        reg up, lo, cb;
        reg [12:0] row;
        begin
            up = a[29:19] >= top;
            l = up ? a[29:0] - {top, 19'h0} : a[29:0];
            lo = up ? pop[2] & pop[3] : pop[0] & pop[1];
            s = l >> pg;
            cb = fb ? s[12] : s[11];
            if (lo)
                row = fb ? s[25:13] : s[24:12];
            else
                row = fb ? s[24:12] : s[23:11];
            xp = {1'b1, row, 4'h0, pg == 2'd2 & l[11], pg != 2'd0 & l[10],
                l[9:3], fb ? s[11:10] : {1'b0, s[10]},
                ~(4'h1 << {up, lo & cb}), ~(8'h01 << a[2:0]),
                a[29:19] >= gb, lo};
        end
    endfunction
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", checks, n_mismatch);
            if (n_mismatch == 0 && checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        {seed, n_mismatch, checks, cyc, n_req} = {32'd8, 128'h0};
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
        {s_axi_arvalid, s_axi_rready, xlat_valid} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, xlat_addr} = 96'h0;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd(16'h8414, 32'h0, 2'b00);
        rd(16'h8418, 32'h0, 2'b00);
        rd(16'h8420, 32'h07ff0000, 2'b00);
        rd(16'h8500, 32'h0, 2'b11);
        wr(16'h8500, 32'h1, 2'b11);
        wr(16'h8414, 32'hffffffff, 2'b00);
        rd(16'h8414, 32'h0000f7ff, 2'b00);
        $display("test registers done");
        for (i = 0; i < 4; i = i + 1) begin
            r = $random(seed);
            ti[i] = {r[7:0], i[1:0]};
            wr(16'h8418, {22'h0, ti[i]}, 2'b00);
            wr(16'h841c, {30'h0, i[1:0]}, 2'b00);
        end
        for (i = 0; i < 4; i = i + 1) begin
            wr(16'h8418, {22'h0, ti[i]}, 2'b00);
            rd(16'h8418, {22'h0, ti[i]}, 2'b00);
            rd(16'h841c, {30'h0, i[1:0]}, 2'b00);
        end
        $display("test tag memory done");
        for (c = 0; c < 24; c = c + 1) begin
            pg = c % 3;
            fb = (c / 3) % 2;
            pop = (c < 6) ? 4'h5 : (c < 12) ? 4'h3 : (c < 18) ? 4'hc : 4'hf;
            r = $random(seed);
            {gb, top} = {r[26:16], r[10:0]};
            wr(16'h8414, {21'h0, gb}, 2'b00);
            wr(16'h8420, {5'h0, top, 8'h0, pop, 1'b0, fb, pg}, 2'b00);
            for (i = 0; i < 8; i = i + 1) begin
                r = $random(seed);
                @(posedge ref_clk);
                xlat_valid <= 1'b1;
                xlat_addr <= (i == 0) ? {2'b0, top, r[18:0]} : r;
                @(posedge ref_clk);
                xlat_valid <= 1'b0;
                n_req = n_req + 1;
                #1;
                chk("xlat", xp(xlat_addr), {out_valid, row_addr_q,
                    col_addr_q, bank_addr_q, chip_select_n_q,
                    byte_mask_n_q, gfx_hit_q,
                    low_order_interleave_q});
            end
        end
        $display("test translation done");
        // Let the far side count the last result before comparing
        @(posedge ref_clk);
        #1;
        chk("hits", n_req, hits);
        // Mid-run reset with a request pending: all returns to idle
        @(posedge ref_clk);
        rst <= 1'b1;
        xlat_valid <= 1'b1;
        xlat_addr <= $random(seed);
        @(posedge ref_clk);
        xlat_valid <= 1'b0;
        @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk("rst_out", {1'b0, 28'h0, 4'hf, 8'hff, 2'h0}, {out_valid,
            row_addr_q, col_addr_q, bank_addr_q, chip_select_n_q,
            byte_mask_n_q, gfx_hit_q, low_order_interleave_q});
        chk("rst_bus", 5'h1c, {s_axi_awready, s_axi_wready,
            s_axi_arready, s_axi_bvalid, s_axi_rvalid});
        rd(16'h8414, 32'h0, 2'b00);
        rd(16'h8418, 32'h0, 2'b00);
        rd(16'h8420, 32'h07ff0000, 2'b00);
        $display("test reset done");
        print_verdict;
    end
endmodule
